// >>> hdl/routing_defines.vh
// register offsets, field layouts and reset values of the routing block
`ifndef ROUTING_DEFINES_VH
`define ROUTING_DEFINES_VH

// printed offsets are register indices; byte address is four times them
`define IDX_CAP2_SEL      8'h01
`define IDX_CAP3_SEL      8'h02
`define IDX_LEVEL1        8'h03
`define IDX_LEVEL2        8'h04
`define IDX_LEVEL3        8'h05
`define IDX_PROTECT1      8'h06
`define IDX_PROTECT2      8'h07
`define IDX_PROTECT3      8'h08
`define IDX_SWITCH1       8'h09
`define IDX_SWITCH2       8'h0a
`define IDX_SWITCH3       8'h0b
`define IDX_GROUP_CFG     8'h0c
`define IDX_CONTROL       8'h10
`define IDX_STATUS        8'h11

`define SEL_W             5
`define SEL_RESET         5'h00
`define REG8_RESET        8'h00
`define GROUP_CFG_RESET   8'hff
`define CTRL_HW_ACQ_BIT   0
`define CTRL_IRQ_EN_BIT   1
`define STAT_FLAG_BIT     0

// selection codes: 1..22 name a pin, anything else is default routing
`define SEL_FIRST_PIN     5'h01
`define SEL_LAST_PIN      5'h16
`define NUM_SEL_PINS      23

// per-pin modes, 2-bit group field codes
`define CFG_PP_LOW        2'b00
`define CFG_PP_HIGH       2'b01
`define CFG_FLOAT_OPEN    2'b10
`define CFG_FLOAT_CLOSED  2'b11
`define HW_ROLE_CAP       2'b00
`define HW_ROLE_ELECTRODE 2'b01

`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10

`endif

// >>> hdl/capture_pin_mux.v
// selects one pin level for an advanced timer capture input
`timescale 1ns/1ns
`default_nettype none
`include "routing_defines.vh"

module capture_pin_mux
(
    input  wire [4:0]  sel,
    input  wire [22:0] pins,
    output reg         capture
);
    // pins[0] is the default pin; pins[k] is the pin for code k
    always @*
    begin
        if (sel >= `SEL_FIRST_PIN && sel <= `SEL_LAST_PIN)
            capture = pins[sel];
        else
            capture = pins[0]; // [R18]
    end
endmodule
`default_nettype wire

// >>> hdl/channel_drive.v
// per-channel pad steering: port control, protected mode, switch
`timescale 1ns/1ns
`default_nettype none
`include "routing_defines.vh"

module channel_drive
(
    input  wire       protect,
    input  wire       switch_bit,
    input  wire       hw_acq,
    input  wire [1:0] group_cfg,
    input  wire       timer_out1,
    input  wire       timer_out2,
    output reg        port_owned,
    output reg        pad_oe,
    output reg        pad_out,
    output reg        analog_close,
    output reg        hyst_off
);
    always @*
    begin
        port_owned   = 1'b0;
        pad_oe       = 1'b0;
        pad_out      = 1'b0;
        analog_close = 1'b0;
        hyst_off     = 1'b0;
        if (!protect)
        begin
            port_owned   = 1'b1;       // [R8]
            analog_close = switch_bit; // [R8] [R10]
        end
        else if (!switch_bit)
        begin
            pad_oe = 1'b1;             // [R9] [R12] [R13]
        end
        else if (!hw_acq)
        begin
            case (group_cfg)           // [R12] [R15]
                `CFG_PP_LOW:
                    pad_oe = 1'b1;
                `CFG_PP_HIGH:
                begin
                    pad_oe  = 1'b1;
                    pad_out = 1'b1;
                end
                `CFG_FLOAT_OPEN:
                    pad_oe = 1'b0;
                `CFG_FLOAT_CLOSED:
                begin
                    analog_close = 1'b1;
                    hyst_off     = 1'b1;
                end
                default:
                    pad_oe = 1'b0;
            endcase
        end
        else
        begin
            // reserved roles leave the pad floating, switch open
            case (group_cfg)           // [R13] [R16] [R17]
                `HW_ROLE_CAP:
                    analog_close = timer_out2;
                `HW_ROLE_ELECTRODE:
                begin
                    pad_oe       = timer_out1;
                    pad_out      = timer_out1;
                    analog_close = timer_out2;
                end
                default:
                    pad_oe = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hdl/analog_io_routing_control.v
// register file and pin steering of the analog I/O routing block
`timescale 1ns/1ns
`default_nettype none
`include "routing_defines.vh"

// How it works
// R1: trigger event has flag and enable bit
// R2: capture2 select field picks timer capture-2 pin
// R3: capture3 select field uses same codes
// R4: low-density build drops both select registers
// R5: software keeps select bits 7:5 clear
// R6: level registers return live pin levels
// R7: register n covers nth pin of groups
// R8: protect clear: port control, switch bit direct
// R9: protect set: only switch and group config
// R10: switch bit 1 closes analog switch
// R11: software leaves switch open for converter
// R12: software acquisition: switch 0 low, 1 group
// R13: hardware acquisition: switch 1 gives timer
// R14: protect and switch registers reset to zero
// R15: group field codes for software acquisition
// R16: group field codes for hardware roles
// R17: timer outputs drive electrode and switch
// R18: unlisted select codes keep default routing
// R19: request high while flag and enable set
// R20: writes to level registers are ignored
module analog_io_routing_control
#(
    parameter LOW_DENSITY = 0
)
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [23:0] pin_level,
    input  wire [22:0] capture2_pins,
    input  wire [22:0] capture3_pins,
    input  wire        trigger_event,
    input  wire        timer_output_1,
    input  wire        timer_output_2,
    output reg         capture2_in,
    output reg         capture3_in,
    output wire [23:0] port_owned,
    output wire [23:0] pad_oe,
    output wire [23:0] pad_out,
    output wire [23:0] analog_close,
    output wire [23:0] hyst_off,
    output wire        trigger_irq,
    output wire        wakeup_wait
);
    reg  [4:0]  capture2_source;
    reg  [4:0]  capture3_source;
    reg  [7:0]  channel_protect [0:2];
    reg  [7:0]  channel_switch  [0:2];
    reg  [7:0]  group_config_reg;
    reg         hw_acquisition_select;
    reg         trigger_irq_enable;
    reg         trigger_flag;
    reg  [7:0]  channel_level [0:2];

    reg         aw_held;
    reg  [7:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    wire        do_write;
    wire [5:0]  w_idx;
    wire [5:0]  r_idx;
    wire        sel_ok;
    wire        c2, c3;
    reg  [31:0] next_rdata;
    reg         next_rvalid_ok;

    assign sel_ok = (LOW_DENSITY == 0);

    // address and data are latched independently, response follows both
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign w_idx = aw_addr[7:2];
    assign r_idx = s_axi_araddr[7:2];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    // registers are at most 8 bits wide; only byte lane 0 carries data
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            capture2_source       <= `SEL_RESET;
            capture3_source       <= `SEL_RESET;
            channel_protect[0]    <= `REG8_RESET; // [R14]
            channel_protect[1]    <= `REG8_RESET; // [R14]
            channel_protect[2]    <= `REG8_RESET; // [R14]
            channel_switch[0]     <= `REG8_RESET; // [R14]
            channel_switch[1]     <= `REG8_RESET; // [R14]
            channel_switch[2]     <= `REG8_RESET; // [R14]
            group_config_reg      <= `GROUP_CFG_RESET;
            hw_acquisition_select <= 1'b0;
            trigger_irq_enable    <= 1'b0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `AXI_OKAY;
        end
        else
        begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `AXI_OKAY;
                if (w_strb[0])
                begin
                    case ({2'b00, w_idx})
                        `IDX_CAP2_SEL:
                            if (sel_ok)
                                capture2_source <= w_data[4:0]; // [R2] [R4]
                            else
                                s_axi_bresp <= `AXI_SLVERR;
                        `IDX_CAP3_SEL:
                            if (sel_ok)
                                capture3_source <= w_data[4:0]; // [R3] [R4]
                            else
                                s_axi_bresp <= `AXI_SLVERR;
                        `IDX_LEVEL1, `IDX_LEVEL2, `IDX_LEVEL3:
                            s_axi_bresp <= `AXI_OKAY; // [R20]
                        `IDX_PROTECT1: channel_protect[0] <= w_data[7:0];
                        `IDX_PROTECT2: channel_protect[1] <= w_data[7:0];
                        `IDX_PROTECT3: channel_protect[2] <= w_data[7:0];
                        `IDX_SWITCH1:  channel_switch[0]  <= w_data[7:0];
                        `IDX_SWITCH2:  channel_switch[1]  <= w_data[7:0];
                        `IDX_SWITCH3:  channel_switch[2]  <= w_data[7:0];
                        `IDX_GROUP_CFG: group_config_reg  <= w_data[7:0];
                        `IDX_CONTROL:
                        begin
                            hw_acquisition_select <=
                                w_data[`CTRL_HW_ACQ_BIT];
                            trigger_irq_enable <=
                                w_data[`CTRL_IRQ_EN_BIT]; // [R1]
                        end
                        `IDX_STATUS:
                            s_axi_bresp <= `AXI_OKAY;
                        default:
                            s_axi_bresp <= `AXI_SLVERR;
                    endcase
                end
            end
        end
    end

    // trigger flag: set wins over a write-one-to-clear in the same cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
            trigger_flag <= 1'b0;
        else if (trigger_event)
            trigger_flag <= 1'b1; // [R1]
        else if (do_write && w_strb[0] && {2'b00, w_idx} == `IDX_STATUS
                 && w_data[`STAT_FLAG_BIT])
            trigger_flag <= 1'b0;
    end

    assign trigger_irq = trigger_flag && trigger_irq_enable; // [R19]
    // the request wakes from wait; halt wake is left to the clock tree
    assign wakeup_wait = trigger_irq; // [R1]

    // pin levels sampled every cycle, so reads see the level of the cycle before the read address is taken
    wire [23:0] level_now;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : gather
            assign level_now[g]      = pin_level[3*g];     // [R6] [R7]
            assign level_now[8 + g]  = pin_level[3*g + 1]; // [R6] [R7]
            assign level_now[16 + g] = pin_level[3*g + 2]; // [R6] [R7]
        end
    endgenerate

    // one process owns the level words; no reset, the value is undefined
    always @(posedge aclk)
    begin
        channel_level[0] <= level_now[7:0];
        channel_level[1] <= level_now[15:8];
        channel_level[2] <= level_now[23:16];
    end

    always @*
    begin
        next_rdata     = 32'h00000000;
        next_rvalid_ok = 1'b1;
        case ({2'b00, r_idx})
            `IDX_CAP2_SEL:
                if (sel_ok)
                    next_rdata[4:0] = capture2_source;
                else
                    next_rvalid_ok = 1'b0;
            `IDX_CAP3_SEL:
                if (sel_ok)
                    next_rdata[4:0] = capture3_source;
                else
                    next_rvalid_ok = 1'b0;
            `IDX_LEVEL1:    next_rdata[7:0] = channel_level[0]; // [R6]
            `IDX_LEVEL2:    next_rdata[7:0] = channel_level[1]; // [R6]
            `IDX_LEVEL3:    next_rdata[7:0] = channel_level[2]; // [R6]
            `IDX_PROTECT1:  next_rdata[7:0] = channel_protect[0];
            `IDX_PROTECT2:  next_rdata[7:0] = channel_protect[1];
            `IDX_PROTECT3:  next_rdata[7:0] = channel_protect[2];
            `IDX_SWITCH1:   next_rdata[7:0] = channel_switch[0];
            `IDX_SWITCH2:   next_rdata[7:0] = channel_switch[1];
            `IDX_SWITCH3:   next_rdata[7:0] = channel_switch[2];
            `IDX_GROUP_CFG: next_rdata[7:0] = group_config_reg;
            `IDX_CONTROL:
            begin
                next_rdata[`CTRL_HW_ACQ_BIT] = hw_acquisition_select;
                next_rdata[`CTRL_IRQ_EN_BIT] = trigger_irq_enable;
            end
            `IDX_STATUS:
                next_rdata[`STAT_FLAG_BIT] = trigger_flag;
            default:
                next_rvalid_ok = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rvalid_ok ? `AXI_OKAY : `AXI_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // per-channel pad steering; channel c is pin (c%3)+1 of group c/3
    genvar c;
    generate
        for (c = 0; c < 24; c = c + 1)
        begin : chan
            channel_drive u_drive
            (
                .protect      (channel_protect[c % 3][c / 3]), // [R7]
                .switch_bit   (channel_switch[c % 3][c / 3]),  // [R7]
                .hw_acq       (hw_acquisition_select),
                .group_cfg    (group_config_reg[2*(c%3)+1 : 2*(c%3)]),
                .timer_out1   (timer_output_1),
                .timer_out2   (timer_output_2),
                .port_owned   (port_owned[c]),
                .pad_oe       (pad_oe[c]),
                .pad_out      (pad_out[c]),
                .analog_close (analog_close[c]),
                .hyst_off     (hyst_off[c])
            );
        end
    endgenerate

    capture_pin_mux u_cap2
    (
        .sel     (capture2_source),
        .pins    (capture2_pins),
        .capture (c2)
    );

    capture_pin_mux u_cap3
    (
        .sel     (capture3_source),
        .pins    (capture3_pins),
        .capture (c3)
    );

    // registered so the timer sees a clean sample of the routed pin
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            capture2_in <= 1'b0;
            capture3_in <= 1'b0;
        end
        else
        begin
            capture2_in <= sel_ok ? c2 : capture2_pins[0]; // [R2] [R4]
            capture3_in <= sel_ok ? c3 : capture3_pins[0]; // [R3] [R4]
        end
    end
endmodule
`default_nettype wire

// >>> test/routing_monitor.sv
// port-level assertions for the routing block
`timescale 1ns/1ns
`default_nettype none
module routing_monitor
(
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        trigger_event,
    input wire        timer_output_2,
    input wire [23:0] port_owned,
    input wire [23:0] pad_oe,
    input wire [23:0] analog_close,
    input wire [23:0] hyst_off,
    input wire        trigger_irq,
    input wire        wakeup_wait
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    a_write_answer: assert property (
        write_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_resp_hold: assert property (
        s_axi_bvalid |=> s_axi_bvalid != $past(s_axi_bready))
        else $error("write answer not held until taken");
    a_reset_state: assert property (
        $rose(aresetn) |-> &port_owned && analog_close == 24'h0)
        else $error("pins not under port control after reset");
    a_wake_irq: assert property (wakeup_wait == trigger_irq)
        else $error("wakeup differs from request");
    a_irq_cause: assert property (
        $rose(trigger_irq) |-> $past(trigger_event) || $rose(s_axi_bvalid))
        else $error("request rose without cause");
    // a mid-run reset also drops the request, so skip the edge after it
    a_irq_drop: assert property (
        $past(aresetn) && $fell(trigger_irq) |-> $rose(s_axi_bvalid))
        else $error("request fell without write");
    a_hyst_float: assert property (
        (hyst_off & ~(analog_close & ~pad_oe & ~port_owned)) == 24'h0)
        else $error("hysteresis off outside float closed");
    a_owner_steady: assert property (
        $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(port_owned))
        else $error("pad owner changed without write");
    a_switch_steady: assert property (
        $past(aresetn) && !$rose(s_axi_bvalid) && $stable(timer_output_2)
        |-> $stable(analog_close))
        else $error("switch moved without cause");
endmodule
`default_nettype wire

// >>> test/pad_model.sv
// far-side pads: a driven pad shows its own output, else the outside level
`timescale 1ns/1ns
`default_nettype none
module pad_model
(
    input  wire [23:0] pad_oe,
    input  wire [23:0] pad_out,
    input  wire [23:0] ext_level,
    output wire [23:0] pin_level
);
    // an undriven pad follows the outside world, never its last value
    assign pin_level = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule
`default_nettype wire

// >>> test/analog_io_routing_control_test.sv
// random and corner-case bench for the routing block
`timescale 1ns/1ns
`default_nettype none
`include "routing_defines.vh"
module analog_io_routing_control_test;
    logic        aclk = 1'h0, aresetn = 1'h0, trigger_event = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, hw = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_rready = 1'h0, timer_output_1 = 1'h0;
    logic        timer_output_2 = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, capture2_in;
    logic        capture3_in, trigger_irq, wakeup_wait;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, cfg = 8'hff;
    logic [7:0]  prot [0:2], sw [0:2];
    logic [22:0] capture2_pins = 23'h0, capture3_pins = 23'h0;
    logic [23:0] ext_level = 24'h0, port_owned, pad_oe, pad_out;
    logic [23:0] analog_close, hyst_off, pin_level;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    integer      num_errors = 0, total_checks = 0, seed = 52, i, j, t;

    always #10 aclk = ~aclk;

    analog_io_routing_control i_dut (.*);
    pad_model i_pads (.*);

    task end_of_test;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task check(input logic [31:0] seen, input logic [31:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want)
            begin
                num_errors = num_errors + 1;
                $display("BAD %0t got %h want %h", $time, seen, want);
            end
        end
    endtask

    task give_up;
        begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    endtask

    // byte address is four times the register index
    task wr(input logic [7:0] idx, input logic [31:0] d,
            input logic [1:0] want = `AXI_OKAY);
        integer n;
        begin
            s_axi_awaddr <= {idx[5:0], 2'h0};
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            n = 0;
            do
            begin
                @(posedge aclk);
                n = n + 1;
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
            end while (!s_axi_bvalid && n < 50);
            s_axi_bready <= 1'h0;
            if (!s_axi_bvalid) give_up;
            check(s_axi_bresp, want);
            @(posedge aclk);
        end
    endtask

    task rd(input logic [7:0] idx, input logic [31:0] d,
            input logic [1:0] want = `AXI_OKAY);
        integer n;
        begin
            s_axi_araddr <= {idx[5:0], 2'h0};
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            n = 0;
            do
            begin
                @(posedge aclk);
                n = n + 1;
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!s_axi_rvalid && n < 50);
            s_axi_rready <= 1'h0;
            if (!s_axi_rvalid) give_up;
            check(s_axi_rresp, want);
            if (want == `AXI_OKAY) check(s_axi_rdata, d);
            @(posedge aclk);
        end
    endtask

    function logic [31:0] lvl(input integer r);
        integer k;
        begin
            lvl = 32'h0;
            for (k = 0; k < 8; k = k + 1) lvl[k] = pin_level[3 * k + r];
        end
    endfunction

    function logic exp_cap(input logic [22:0] p, input logic [4:0] c);
        exp_cap = (c >= 5'h01 && c <= 5'h16) ? p[c] : p[0];
    endfunction

    // fields {owner, switch, drive, level, hyst}; unspecified ones masked
    task pins_ok;
        integer     c;
        logic       p, s;
        logic [1:0] f;
        logic [4:0] m, e, g;
        begin
            for (c = 0; c < 24; c = c + 1)
            begin
                p = prot[c % 3][c / 3];
                s = sw[c % 3][c / 3];
                f = cfg[2 * (c % 3) +: 2];
                m = 5'h18;
                e = {1'h1, s, 3'h0};
                if (p && !s)
                begin
                    m = 5'h16;
                    e = 5'h04;
                end
                else if (p && !hw)
                begin
                    m = f[1] ? 5'h1d : 5'h17;
                    e = f[1] ? {1'h0, f[0], 2'h0, f[0]} : {3'h1, f[0], 1'h0};
                end
                else if (p)
                begin
                    m = f == 2'h1 ? 5'h1e : f == 2'h0 ? 5'h18 : 5'h10;
                    e = {1'h0, timer_output_2, {2{timer_output_1}}, 1'h0};
                end
                g = {port_owned[c], analog_close[c], pad_oe[c], pad_out[c],
                     hyst_off[c]};
                check(g & m, e & m);
            end
        end
    endtask

    initial
    begin
        for (i = 0; i < 3; i = i + 1)
        begin
            prot[i] = 8'h0;
            sw[i] = 8'h0;
        end
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        // switches start open, leaving the converter in charge
        pins_ok;
        for (i = 1; i < 12; i = i + 1)
            if (i < 3 || i > 5) rd(i, 32'h0);
        rd(12, 32'hff);
        // software codes rotated over the fields, then hardware roles
        for (j = 0; j < 7; j = j + 1)
        begin
            hw = (j > 3);
            cfg = j > 5 ? 8'he6 : j > 4 ? 8'hc4 : j > 3 ? 8'hd1
                : {2'h3, j[1:0] + 2'h2, j[1:0] + 2'h1, j[1:0]};
            wr(12, {24'h0, cfg});
            wr(16, {31'h0, hw});
            for (i = 0; i < 3; i = i + 1)
            begin
                t = $random(seed);
                prot[i] = t[7:0];
                sw[i] = t[15:8];
                wr(6 + i, {24'h0, prot[i]});
                wr(9 + i, {24'h0, sw[i]});
                rd(6 + i, {24'h0, prot[i]});
                rd(9 + i, {24'h0, sw[i]});
            end
            for (t = 0; t < 4; t = t + 1)
            begin
                {timer_output_1, timer_output_2} <= t[1:0];
                @(posedge aclk);
                @(posedge aclk);
                pins_ok;
            end
        end
        for (i = 0; i < 3; i = i + 1)
        begin
            t = $random(seed);
            ext_level <= t[23:0];
            @(posedge aclk);
            @(posedge aclk);
            rd(3 + i, lvl(i));
            wr(3 + i, ~lvl(i));
            rd(3 + i, lvl(i));
        end
        // codes stay within 4:0 so the reserved bits are written as zero
        for (j = 0; j < 32; j = j + 1)
        begin
            wr(1, j);
            wr(2, 31 - j);
            t = $random(seed);
            capture2_pins <= t[22:0];
            capture3_pins <= ~t[22:0];
            @(posedge aclk);
            @(posedge aclk);
            check(capture2_in, exp_cap(t[22:0], j[4:0]));
            check(capture3_in, exp_cap(~t[22:0], 5'h1f - j[4:0]));
            rd(1, j);
        end
        wr(16, 32'h2);
        trigger_event <= 1'h1;
        @(posedge aclk);
        trigger_event <= 1'h0;
        @(posedge aclk);
        check(trigger_irq, 1'h1);
        check(wakeup_wait, 1'h1);
        rd(17, 32'h1);
        wr(17, 32'h1);
        check(trigger_irq, 1'h0);
        wr(16, 32'h0);
        trigger_event <= 1'h1;
        @(posedge aclk);
        trigger_event <= 1'h0;
        @(posedge aclk);
        check(trigger_irq, 1'h0);
        rd(17, 32'h1);
        rd(15, 32'h0, `AXI_SLVERR);
        wr(15, 32'h5a, `AXI_SLVERR);
        // a reset in mid-run must hand every pin back to port control
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 3; i = i + 1)
        begin
            prot[i] = 8'h0;
            sw[i] = 8'h0;
        end
        @(posedge aclk);
        pins_ok;
        check(trigger_irq, 1'h0);
        rd(17, 32'h0);
        rd(8, 32'h0);
        end_of_test;
    end
endmodule

bind analog_io_routing_control routing_monitor i_mon (.*);
`default_nettype wire
